// ==== sbtc_pkg.sv ====
/*
  Shared constants and types of the sixteen bit timer counter: register
  indices, field layouts, reset values, mode codes and bus responses.
  Assumes a 32-bit AXI4-Lite master and a 50 MHz core clock that is
  also the instruction clock.
*/
// Behaviour
// [RL1] Counter mode advances only on rising edges of the external input.
// [RL2] After enable in counter mode, one falling edge must pass before counting.
// [RL3] Crystal oscillator runs only while control bit 3 is set.
// [RL4] The crystal oscillator and counter mode keep running during sleep.
// [RL5] Software waits its own start-up delay after enabling the oscillator.
// [RL6] Count runs 0000h up to FFFFh and wraps to 0000h.
// [RL7] Each natural wrap sets the sticky overflow flag, bit 0 of index 0Ch.
// [RL8] Overflow raises the interrupt only while enable bit 0 at 8Ch is set.
// [RL9] Compare mode 1011 trigger resets the count and starts a conversion.
// [RL10] A trigger reset never sets the overflow flag.
// [RL11] Trigger reset is applied only in timer or synchronized counter mode.
// [RL12] A count write in the trigger cycle wins over the trigger reset.
// [RL13] In trigger mode the compare pair is the period of the count.
// [RL14] Count bytes at 0Eh and 0Fh, read/write, not cleared by reset.
// [RL15] Timer mode counts every instruction cycle, the core clock.
// [RL16] Prescale field bits 5-4 divides by 1, 2, 4 or 8.
// [RL17] Sync-disable bit uses the external input unsynchronized; ignored in timer mode. Here the pin stays synchronized; the bit only blocks the trigger reset.
// [RL18] Counting only while on bit 0 is set; clearing holds the value.
package sbtc_pkg;
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned OSC_MAX_HZ = 200_000;
  localparam int unsigned AW         = 12;
  localparam int unsigned IDX_W      = 10;
  localparam int unsigned CNT_W      = 16;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS    = 10'h00C;
  localparam logic [IDX_W-1:0] IDX_CLR      = 10'h00D;
  localparam logic [IDX_W-1:0] IDX_CNT_LO   = 10'h00E;
  localparam logic [IDX_W-1:0] IDX_CNT_HI   = 10'h00F;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h010;
  localparam logic [IDX_W-1:0] IDX_CMP_LO   = 10'h015;
  localparam logic [IDX_W-1:0] IDX_CMP_HI   = 10'h016;
  localparam logic [IDX_W-1:0] IDX_CMP_MODE = 10'h017;
  localparam logic [IDX_W-1:0] IDX_EN       = 10'h08C;

  localparam int unsigned OVF_BIT      = 0;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  FLAGS_RST    = 8'h00;
  localparam logic [7:0]  EN_RST       = 8'h00;
  localparam logic [15:0] CMP_RST      = 16'h0000;
  localparam logic [3:0]  CMP_MODE_RST = 4'h0;
  localparam logic [3:0]  TRIG_MODE    = 4'hB;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register layout, bit 5 down to bit 0
  typedef struct packed {
    logic [1:0] ps;
    logic       osc_en;
    logic       sync_dis;
    logic       cs;
    logic       on;
  } sbtc_ctrl_t;

  // One register write from the bus slave
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [7:0]       data;
  } sbtc_wr_t;
endpackage : sbtc_pkg

// ==== sbtc_edge.sv ====
/*
  Two-stage synchronizer with rising and falling edge detection.
  Assumes the pin is asynchronous to clk_i and slower than half its rate.
*/
`timescale 1ns/100ps
module sbtc_edge (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  // Shift chain; only sync_ff reads meta_ff
  always_comb
  begin
    nxt_meta = pin_i;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // Edges seen on the settled copy
  assign rise_o = sync_ff & ~prev_ff;
  assign fall_o = ~sync_ff & prev_ff;
endmodule : sbtc_edge

// ==== sbtc_axil.sv ====
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes the register file answers hits and read data combinationally.
*/
`timescale 1ns/100ps
module sbtc_axil (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [sbtc_pkg::AW-1:0]   awaddr_i,
  input  wire logic                      awvalid_i,
  output logic                           awready_o,
  input  wire logic [31:0]               wdata_i,
  input  wire logic [3:0]                wstrb_i,
  input  wire logic                      wvalid_i,
  output logic                           wready_o,
  output logic [1:0]                     bresp_o,
  output logic                           bvalid_o,
  input  wire logic                      bready_i,
  input  wire logic [sbtc_pkg::AW-1:0]   araddr_i,
  input  wire logic                      arvalid_i,
  output logic                           arready_o,
  output logic [31:0]                    rdata_o,
  output logic [1:0]                     rresp_o,
  output logic                           rvalid_o,
  input  wire logic                      rready_i,
  output sbtc_pkg::sbtc_wr_t             wr_o,
  output logic                           wr_vld_o,
  input  wire logic                      wr_hit_i,
  output logic [sbtc_pkg::IDX_W-1:0]     rd_idx_o,
  input  wire logic [7:0]                rd_data_i,
  input  wire logic                      rd_hit_i
);
  logic                       aw_got_ff, nxt_aw_got;
  logic                       w_got_ff, nxt_w_got;
  logic [sbtc_pkg::IDX_W-1:0] awidx_ff, nxt_awidx;
  logic [7:0]                 wdata_ff, nxt_wdata;
  logic                       wstrb0_ff, nxt_wstrb0;
  logic                       bvalid_ff, nxt_bvalid;
  logic [1:0]                 bresp_ff, nxt_bresp;
  logic                       rvalid_ff, nxt_rvalid;
  logic [31:0]                rdata_ff, nxt_rdata;
  logic [1:0]                 rresp_ff, nxt_rresp;
  logic                       fire;

  assign awready_o = ~aw_got_ff & ~bvalid_ff;
  assign wready_o  = ~w_got_ff & ~bvalid_ff;
  assign arready_o = ~rvalid_ff;
  assign fire      = aw_got_ff & w_got_ff & ~bvalid_ff;
  // Lane 0 only: narrower registers sit in the low byte
  assign wr_vld_o  = fire & wstrb0_ff;
  assign wr_o      = '{idx: awidx_ff, data: wdata_ff};
  assign rd_idx_o  = araddr_i[sbtc_pkg::AW-1:2];
  assign bvalid_o  = bvalid_ff;
  assign bresp_o   = bresp_ff;
  assign rvalid_o  = rvalid_ff;
  assign rdata_o   = rdata_ff;
  assign rresp_o   = rresp_ff;

  // Address and data taken in either order, response after both
  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awidx  = awidx_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (awvalid_i && awready_o)
    begin
      nxt_aw_got = 1'b1;
      nxt_awidx  = awaddr_i[sbtc_pkg::AW-1:2];
    end
    if (wvalid_i && wready_o)
    begin
      nxt_w_got  = 1'b1;
      nxt_wdata  = wdata_i[7:0];
      nxt_wstrb0 = wstrb_i[0];
    end
    if (fire)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_hit_i ? sbtc_pkg::RESP_OKAY : sbtc_pkg::RESP_SLVERR;
    end
    if (bvalid_ff && bready_i)
      nxt_bvalid = 1'b0;
    if (arvalid_i && arready_o)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = {24'h000000, rd_data_i};
      nxt_rresp  = rd_hit_i ? sbtc_pkg::RESP_OKAY : sbtc_pkg::RESP_SLVERR;
    end
    if (rvalid_ff && rready_i)
      nxt_rvalid = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awidx_ff  <= '0;
      wdata_ff  <= 8'h00;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= sbtc_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= sbtc_pkg::RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
      awidx_ff  <= nxt_awidx;
      wdata_ff  <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end
endmodule : sbtc_axil

// ==== sbtc_top.sv ====
/*
  Sixteen bit timer counter: prescaled count of the instruction clock or
  of an external input, overflow interrupt, compare trigger reset and a
  low-power crystal amplifier. Registers over AXI4-Lite.
  Assumes SLEEP_I and ADC_ENABLE_I come from logic on CORE_CLK_I.
*/
`timescale 1ns/100ps
module sbtc_top (
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RST_N_I,
  input  wire logic [sbtc_pkg::AW-1:0] S_AXI_AWADDR_I,
  input  wire logic                    S_AXI_AWVALID_I,
  output logic                         S_AXI_AWREADY_O,
  input  wire logic [31:0]             S_AXI_WDATA_I,
  input  wire logic [3:0]              S_AXI_WSTRB_I,
  input  wire logic                    S_AXI_WVALID_I,
  output logic                         S_AXI_WREADY_O,
  output logic [1:0]                   S_AXI_BRESP_O,
  output logic                         S_AXI_BVALID_O,
  input  wire logic                    S_AXI_BREADY_I,
  input  wire logic [sbtc_pkg::AW-1:0] S_AXI_ARADDR_I,
  input  wire logic                    S_AXI_ARVALID_I,
  output logic                         S_AXI_ARREADY_O,
  output logic [31:0]                  S_AXI_RDATA_O,
  output logic [1:0]                   S_AXI_RRESP_O,
  output logic                         S_AXI_RVALID_O,
  input  wire logic                    S_AXI_RREADY_I,
  input  wire logic                    EXT_CLK_I,
  input  wire logic                    CRYSTAL_INPUT_PIN_I,
  output logic                         CRYSTAL_OUTPUT_PIN_O,
  output logic                         CRYSTAL_OUTPUT_PIN_OE_O,
  input  wire logic                    SLEEP_I,
  input  wire logic                    ADC_ENABLE_I,
  output logic                         ADC_START_O,
  output logic                         TRIG_EVENT_O,
  output logic                         IRQ_O
);
  sbtc_pkg::sbtc_ctrl_t       ctrl_ff, nxt_ctrl;
  logic                       en_ff, nxt_en;
  logic                       flag_ff, nxt_flag;
  logic [15:0]                cmp_ff, nxt_cmp;
  logic [3:0]                 cmode_ff, nxt_cmode;
  logic [15:0]                count_ff, nxt_count;
  logic [2:0]                 ps_cnt_ff, nxt_ps_cnt;
  logic                       armed_ff, nxt_armed;
  logic                       trig_ff, nxt_trig;
  logic                       adc_ff, nxt_adc;
  sbtc_pkg::sbtc_wr_t         wr;
  logic                       wr_vld, wr_hit, rd_hit;
  logic [sbtc_pkg::IDX_W-1:0] rd_idx;
  logic [7:0]                 rd_data;
  logic                       src_pin, rise, fall;
  logic                       src_event, run, tick;
  logic [2:0]                 ps_mask;
  logic                       cnt_wr, trig_mode, trig_ok, period_hit, wrap;

  sbtc_axil u_axil (
    .clk_i     (CORE_CLK_I),
    .rst_n_i   (RST_N_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .wr_o      (wr),
    .wr_vld_o  (wr_vld),
    .wr_hit_i  (wr_hit),
    .rd_idx_o  (rd_idx),
    .rd_data_i (rd_data),
    .rd_hit_i  (rd_hit)
  );

  // Crystal amplifier: inverter off when disabled to save power
  assign CRYSTAL_OUTPUT_PIN_O    = ctrl_ff.osc_en & ~CRYSTAL_INPUT_PIN_I; // [RL3]
  assign CRYSTAL_OUTPUT_PIN_OE_O = ctrl_ff.osc_en; // [RL3]
  // Oscillator runs from the pin itself, so sleep does not stop it
  assign src_pin = ctrl_ff.osc_en ? CRYSTAL_INPUT_PIN_I : EXT_CLK_I; // [RL4]

  sbtc_edge u_edge (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   (src_pin),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // Count source: core clock outside sleep in timer mode, armed rising edge otherwise
  always_comb
  begin
    src_event  = ctrl_ff.cs ? (armed_ff & rise) : ~SLEEP_I; // [RL1] [RL15] [RL4]
    run        = ctrl_ff.on & src_event; // [RL18]
    ps_mask    = 3'((4'h1 << ctrl_ff.ps) - 4'h1); // [RL16]
    tick       = run & (ps_cnt_ff == ps_mask); // [RL16]
    cnt_wr     = wr_vld & ((wr.idx == sbtc_pkg::IDX_CNT_LO) | (wr.idx == sbtc_pkg::IDX_CNT_HI));
    trig_mode  = cmode_ff == sbtc_pkg::TRIG_MODE; // [RL9]
    // Pin is always resynchronized here; async mode only drops the reset
    trig_ok    = ~(ctrl_ff.cs & ctrl_ff.sync_dis); // [RL11] [RL17]
    period_hit = trig_mode & tick & (count_ff == cmp_ff); // [RL13]
    wrap       = tick & ~cnt_wr & (count_ff == sbtc_pkg::CNT_MAX) & ~(period_hit & trig_ok); // [RL10]
  end

  // Count value; write first, then trigger, then increment
  always_comb
  begin
    nxt_count = count_ff;
    if (cnt_wr)
    begin
      if (wr.idx == sbtc_pkg::IDX_CNT_LO)
        nxt_count[7:0] = wr.data; // [RL12] [RL14]
      else
        nxt_count[15:8] = wr.data; // [RL12] [RL14]
    end
    else if (period_hit && trig_ok)
      nxt_count = sbtc_pkg::CNT_ZERO; // [RL9] [RL13]
    else if (tick)
      nxt_count = count_ff + 16'h0001; // [RL6]
  end

  // No reset: count survives every reset but power-up
  always_ff @(posedge CORE_CLK_I)
  begin
    count_ff <= nxt_count; // [RL14]
  end

  // Prescaler, arming and trigger pulses
  always_comb
  begin
    nxt_ps_cnt = ps_cnt_ff;
    if (!ctrl_ff.on || cnt_wr)
      nxt_ps_cnt = 3'h0;
    else if (run)
      nxt_ps_cnt = tick ? 3'h0 : ps_cnt_ff + 3'h1; // [RL16]
    // Disarm whenever the counter leaves enabled counter mode
    nxt_armed = (ctrl_ff.on & ctrl_ff.cs) ? (armed_ff | fall) : 1'b0; // [RL2]
    nxt_trig  = period_hit;
    nxt_adc   = period_hit & ADC_ENABLE_I; // [RL9]
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ps_cnt_ff <= 3'h0;
      armed_ff  <= 1'b0;
      trig_ff   <= 1'b0;
      adc_ff    <= 1'b0;
    end
    else
    begin
      ps_cnt_ff <= nxt_ps_cnt;
      armed_ff  <= nxt_armed;
      trig_ff   <= nxt_trig;
      adc_ff    <= nxt_adc;
    end
  end

  // Software registers; the overflow set wins over a clear
  always_comb
  begin
    nxt_ctrl  = ctrl_ff;
    nxt_en    = en_ff;
    nxt_cmp   = cmp_ff;
    nxt_cmode = cmode_ff;
    nxt_flag  = flag_ff;
    if (wr_vld)
    begin
      unique case (wr.idx)
        sbtc_pkg::IDX_CTRL:     nxt_ctrl = sbtc_pkg::sbtc_ctrl_t'(wr.data[5:0]);
        sbtc_pkg::IDX_EN:       nxt_en = wr.data[sbtc_pkg::OVF_BIT];
        sbtc_pkg::IDX_CMP_LO:   nxt_cmp[7:0] = wr.data;
        sbtc_pkg::IDX_CMP_HI:   nxt_cmp[15:8] = wr.data;
        sbtc_pkg::IDX_CMP_MODE: nxt_cmode = wr.data[3:0];
        sbtc_pkg::IDX_CLR:      nxt_flag = flag_ff & ~wr.data[sbtc_pkg::OVF_BIT];
        default:                nxt_flag = flag_ff;
      endcase
    end
    if (wrap)
      nxt_flag = 1'b1; // [RL7]
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_ff  <= sbtc_pkg::sbtc_ctrl_t'(sbtc_pkg::CTRL_RST[5:0]);
      en_ff    <= sbtc_pkg::EN_RST[sbtc_pkg::OVF_BIT];
      flag_ff  <= sbtc_pkg::FLAGS_RST[sbtc_pkg::OVF_BIT];
      cmp_ff   <= sbtc_pkg::CMP_RST;
      cmode_ff <= sbtc_pkg::CMP_MODE_RST;
    end
    else
    begin
      ctrl_ff  <= nxt_ctrl;
      en_ff    <= nxt_en;
      flag_ff  <= nxt_flag;
      cmp_ff   <= nxt_cmp;
      cmode_ff <= nxt_cmode;
    end
  end

  // Read mux and decode; clear register is write-only and reads zero
  always_comb
  begin
    rd_data = 8'h00;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      sbtc_pkg::IDX_FLAGS:    rd_data[sbtc_pkg::OVF_BIT] = flag_ff;
      sbtc_pkg::IDX_CLR:      rd_data = 8'h00;
      sbtc_pkg::IDX_CNT_LO:   rd_data = count_ff[7:0];
      sbtc_pkg::IDX_CNT_HI:   rd_data = count_ff[15:8];
      sbtc_pkg::IDX_CTRL:     rd_data = {2'h0, ctrl_ff};
      sbtc_pkg::IDX_EN:       rd_data[sbtc_pkg::OVF_BIT] = en_ff;
      sbtc_pkg::IDX_CMP_LO:   rd_data = cmp_ff[7:0];
      sbtc_pkg::IDX_CMP_HI:   rd_data = cmp_ff[15:8];
      sbtc_pkg::IDX_CMP_MODE: rd_data = {4'h0, cmode_ff};
      default:                rd_hit = 1'b0;
    endcase
    wr_hit = (wr.idx == sbtc_pkg::IDX_FLAGS) | (wr.idx == sbtc_pkg::IDX_CLR) |
             (wr.idx == sbtc_pkg::IDX_CNT_LO) | (wr.idx == sbtc_pkg::IDX_CNT_HI) |
             (wr.idx == sbtc_pkg::IDX_CTRL) | (wr.idx == sbtc_pkg::IDX_EN) |
             (wr.idx == sbtc_pkg::IDX_CMP_LO) | (wr.idx == sbtc_pkg::IDX_CMP_HI) |
             (wr.idx == sbtc_pkg::IDX_CMP_MODE);
  end

  // Outputs
  assign IRQ_O        = flag_ff & en_ff; // [RL8]
  assign TRIG_EVENT_O = trig_ff;
  assign ADC_START_O  = adc_ff;

  // Checks
  a_wrap_sets_flag: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL7]
    wrap |=> flag_ff) else $error("overflow flag not set on wrap");

  a_irq_gated: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL8]
    !en_ff |-> !IRQ_O) else $error("interrupt while disabled");

  // Case equality: the count is unknown until software first writes it
  a_held_when_off: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL18]
    (!ctrl_ff.on && !cnt_wr) |=> count_ff === $past(count_ff)) else $error("count moved while off");

  a_timer_steps: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL15]
    (ctrl_ff.on && !ctrl_ff.cs && !SLEEP_I && ctrl_ff.ps == 2'h0 && !cnt_wr && !trig_mode)
    |=> count_ff == $past(count_ff) + 16'h0001) else $error("timer did not step");

  a_rise_only: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL1]
    (ctrl_ff.cs && !rise && !cnt_wr) |=> $stable(count_ff)) else $error("count without rise");

  a_arm_first: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL2]
    ($rose(ctrl_ff.on & ctrl_ff.cs) ##0 (!fall && !cnt_wr)[*2]) |=> !armed_ff)
    else $error("armed without falling edge");

  a_trig_reset: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL9]
    (period_hit && trig_ok && !cnt_wr) |=> count_ff == 16'h0000 && (!flag_ff || $past(flag_ff)))
    else $error("trigger reset failed");

  a_trig_no_flag: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL10]
    (period_hit && trig_ok && !flag_ff && !(wr_vld && wr.idx == sbtc_pkg::IDX_CLR)) |=> !flag_ff)
    else $error("trigger set overflow flag");

  a_async_no_trig: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL11]
    (period_hit && !trig_ok && !cnt_wr) |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("trigger applied in async mode");

  a_write_wins: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL12]
    (period_hit && wr_vld && wr.idx == sbtc_pkg::IDX_CNT_LO) |=> count_ff[7:0] == $past(wr.data))
    else $error("trigger beat a write");

  a_prescale_gap: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL16]
    (tick && ctrl_ff.ps != 2'h0 && $stable(ctrl_ff)) |=> !tick) else $error("prescale too fast");

  a_osc_off: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL3]
    !ctrl_ff.osc_en |-> !CRYSTAL_OUTPUT_PIN_O && !CRYSTAL_OUTPUT_PIN_OE_O)
    else $error("oscillator driven while off");

  // Flag life cycle and converter start
  a_clear_flag: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL7]
    (wr_vld && wr.idx == sbtc_pkg::IDX_CLR && wr.data[sbtc_pkg::OVF_BIT] && !wrap) |=> !flag_ff)
    else $error("overflow flag not cleared");

  a_flag_sticky: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL7]
    (flag_ff && !(wr_vld && wr.idx == sbtc_pkg::IDX_CLR)) |=> flag_ff) else $error("overflow flag lost");

  a_adc_start: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL9]
    (period_hit && ADC_ENABLE_I) |=> ADC_START_O) else $error("conversion not started");

  // Main scenarios reached
  c_wrap: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) wrap ##1 IRQ_O);
  c_period: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) period_hit && trig_ok);
  c_ext_count: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) tick && ctrl_ff.cs);
  c_sleep_count: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) tick && SLEEP_I);
endmodule : sbtc_top

// ==== sbtc_src.sv ====
/*
  Far-side model: a pulse source on the external count pin.
  Assumes go_i is a one-cycle request on the core clock.
*/
`timescale 1ns/100ps
module sbtc_src (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] n_i,
  input  wire logic [3:0] half_i,
  output logic            pin_o,
  output logic            busy_o
);
  initial pin_o = 1'b0;
  initial busy_o = 1'b0;
  // Pin idles low, so every burst opens with a rise
  always
  begin
    @(posedge clk_i);
    if (go_i)
    begin
      busy_o <= 1'b1;
      repeat (n_i)
      begin
        repeat (half_i) @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (half_i) @(posedge clk_i);
        pin_o <= 1'b0;
      end
      busy_o <= 1'b0;
    end
  end
endmodule : sbtc_src

// ==== testbench.sv ====
/*
  Self-checking bench of the timer counter: AXI4-Lite master tasks,
  LFSR stimulus and a pulse source. Assumes the 50 MHz core clock only.
*/
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
  logic [31:0] w_data = 32'h0, v, rdata;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic        go = 1'b0, sleep = 1'b0, adc_en = 1'b0, ext, busy;
  logic        awready, wready, bvalid, arready, rvalid, xo, xoe, adc_st, trig, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  npul = 3'h2;
  logic [3:0]  half = 4'h4;
  logic [15:0] seed = 16'h8863, c;
  int          num_errors = 0, n_compared = 0, cyc = 0, t0;

  sbtc_top uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(aw_addr), .S_AXI_AWVALID_I(aw_v),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(w_data), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(w_v),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(b_r),
    .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(r_r), .EXT_CLK_I(ext),
    .CRYSTAL_INPUT_PIN_I(ext), .CRYSTAL_OUTPUT_PIN_O(xo), .CRYSTAL_OUTPUT_PIN_OE_O(xoe),
    .SLEEP_I(sleep), .ADC_ENABLE_I(adc_en), .ADC_START_O(adc_st), .TRIG_EVENT_O(trig), .IRQ_O(irq));
  sbtc_src src (.clk_i(clk), .go_i(go), .n_i(npul), .half_i(half), .pin_o(ext), .busy_o(busy));

  // Clock and hang limit
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      num_errors++;
      conclude();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %0h", $time, what, got);
    end
  endtask : chk

  // Write and read hold each channel until its own ready edge
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    aw_addr <= {idx, 2'b00};
    w_data <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      @(posedge clk);
      if (aw_v && awready) aw_v <= 1'b0;
      if (w_v && wready) w_v <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    b_r <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    @(posedge clk);
    ar_addr <= {idx, 2'b00};
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      @(posedge clk);
      if (ar_v && arready) ar_v <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    r_r <= 1'b0;
  endtask : rd

  task automatic wait_trig;
    @(posedge clk);
    for (int i = 0; i < 40 && trig !== 1'b1; i++) @(posedge clk);
    chk(trig, 1, "trigger");
  endtask : wait_trig

  task automatic conclude;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(sbtc_pkg::IDX_EN);
    chk(v, 0, "enable reset");
    rd(sbtc_pkg::IDX_FLAGS);
    chk(v, 0, "flag reset");
    chk(xoe, 0, "osc off");
    rd(10'h020);
    chk(v, 0, "unmapped read data");
    chk(resp, sbtc_pkg::RESP_SLVERR, "unmapped read");
    wr(10'h020, 8'hFF);
    chk(resp, sbtc_pkg::RESP_SLVERR, "unmapped write");
    $display("reset test done");
    // Every prescale code over a 200-cycle window; stop holds the value
    for (int ps = 0; ps < 4; ps++)
    begin
      wr(sbtc_pkg::IDX_CNT_LO, 8'h00);
      wr(sbtc_pkg::IDX_CNT_HI, 8'h00);
      wr(sbtc_pkg::IDX_CTRL, {2'b00, ps[1:0], 4'h1});
      repeat (200) @(posedge clk);
      wr(sbtc_pkg::IDX_CTRL, 8'h00);
      rd(sbtc_pkg::IDX_CNT_LO);
      chk((v << ps) >= 196 && (v << ps) <= 216, 1, "prescaled count");
    end
    $display("prescale test done");
    // Wrap from a random start near the top, then mask and clear
    seed = lfsr(seed);
    wr(sbtc_pkg::IDX_CNT_LO, {1'b0, seed[6:0]}); // Keeps the post-wrap count below 100h
    wr(sbtc_pkg::IDX_CNT_HI, 8'hFF);
    wr(sbtc_pkg::IDX_CTRL, 8'h01);
    repeat (300) @(posedge clk);
    wr(sbtc_pkg::IDX_CTRL, 8'h00);
    rd(sbtc_pkg::IDX_CNT_HI);
    chk(v, 0, "wrapped high byte");
    rd(sbtc_pkg::IDX_FLAGS);
    chk(v, 1, "overflow flag");
    chk(irq, 0, "masked irq");
    wr(sbtc_pkg::IDX_EN, 8'h01);
    @(posedge clk);
    chk(irq, 1, "irq");
    wr(sbtc_pkg::IDX_CLR, 8'h01);
    @(posedge clk);
    chk(irq, 0, "irq cleared");
    $display("overflow test done");
    // Compare value as period, converter start, no flag
    seed = lfsr(seed);
    c = 16'h0003 + seed[2:0];
    adc_en <= 1'b1;
    wr(sbtc_pkg::IDX_CMP_LO, c[7:0]);
    wr(sbtc_pkg::IDX_CMP_HI, 8'h00);
    wr(sbtc_pkg::IDX_CMP_MODE, {4'h0, sbtc_pkg::TRIG_MODE});
    wr(sbtc_pkg::IDX_CNT_LO, 8'h00);
    wr(sbtc_pkg::IDX_CTRL, 8'h01);
    wait_trig();
    t0 = cyc;
    chk(adc_st, 1, "conversion start");
    wait_trig();
    chk(cyc - t0, c + 1, "period");
    wr(sbtc_pkg::IDX_CTRL, 8'h00);
    rd(sbtc_pkg::IDX_FLAGS);
    chk(v, 0, "no flag on trigger");
    adc_en <= 1'b0;
    $display("trigger test done");
    wr(sbtc_pkg::IDX_CMP_LO, 8'h00);
    // Counter mode: crystal in sleep, then external pin with the sync-disable bit set
    for (int k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      npul <= 3'h2 + seed[1:0];
      half <= (k == 0) ? 4'h7 : 4'h4;
      sleep <= (k == 0);
      wr(sbtc_pkg::IDX_CNT_LO, 8'h00);
      wr(sbtc_pkg::IDX_CNT_HI, 8'h00);
      wr(sbtc_pkg::IDX_CMP_MODE, {4'h0, (k == 0) ? 4'h0 : sbtc_pkg::TRIG_MODE});
      wr(sbtc_pkg::IDX_CTRL, (k == 0) ? 8'h0B : 8'h07);
      chk(xoe, k == 0, "osc enable");
      repeat (20) @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 200 && busy === 1'b1; i++) @(posedge clk);
      repeat (8) @(posedge clk);
      wr(sbtc_pkg::IDX_CTRL, 8'h00);
      rd(sbtc_pkg::IDX_CNT_LO);
      chk(v, npul - 1, "edge count");
    end
    $display("counter test done");
    conclude();
  end
endmodule : testbench
